// ==== hw/rc_readout_pkg.sv ====
package rc_readout_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ            = 125_000_000;
  localparam int STARTUP_MS        = 100;
  // longest time, rounds down
  localparam int STARTUP_CYCLES    = (CLK_HZ / 1000) * STARTUP_MS;
  localparam int FAULT_REACT_US    = 200;
  localparam int FAULT_REACT_CYCLES = (CLK_HZ / 1_000_000) * FAULT_REACT_US;
  localparam int FAULT_FREQ_MIN_HZ = 11_000;
  localparam int FAULT_FREQ_MAX_HZ = 21_000;
  // mid band keeps margin against clock tolerance on both sides
  localparam int FAULT_FREQ_HZ     = (FAULT_FREQ_MIN_HZ + FAULT_FREQ_MAX_HZ) / 2;
  localparam int FAULT_HALF_CYCLES = CLK_HZ / (2 * FAULT_FREQ_HZ);
  localparam logic [11:0] FAULT_HALF_LAST = 12'(FAULT_HALF_CYCLES - 1);

  // ----------------------------------------------------------------
  // bitstream rate
  // ----------------------------------------------------------------
  localparam int SD_RATE_MHZ = 48;
  localparam int CLK_MHZ     = CLK_HZ / 1_000_000;
  localparam logic [7:0] SD_RATE_STEP = 8'(SD_RATE_MHZ);
  localparam logic [7:0] SD_RATE_WRAP = 8'(CLK_MHZ);

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BYTES = 5;
  localparam int FRAME_BITS  = FRAME_BYTES * 8;
  localparam logic [5:0] FRAME_BITS_LAST = 6'(FRAME_BITS - 1);
  localparam logic [15:0] ZERO_CODE      = 16'h8000;

  // ----------------------------------------------------------------
  // error code fields
  // ----------------------------------------------------------------
  localparam logic [9:0] ERR_ONES            = 10'h3ff;
  localparam logic [1:0] RESERVED_LATER_USE  = 2'h0;
  localparam logic       ERR_ZERO_BIT        = 1'h0;

  // ----------------------------------------------------------------
  // fault threshold, sensitivity in hundredths of lsb per ma
  // ----------------------------------------------------------------
  localparam int FAULT_THRESH_MA       = 152;
  localparam int SENS_CENTI_LSB_PER_MA = 8799;
  localparam logic [16:0] FAULT_CURRENT_THRESHOLD =
    17'((FAULT_THRESH_MA * SENS_CENTI_LSB_PER_MA) / 100);

  // ----------------------------------------------------------------
  // check byte
  // ----------------------------------------------------------------
  localparam logic [7:0] CRC_POLY   = 8'h07;
  localparam logic [7:0] CRC_PRESET = 8'hff;
  localparam int         CRC_TOP    = 7;

  typedef enum logic [0:0] {
    LINK_IDLE  = 1'b0,
    LINK_SHIFT = 1'b1
  } link_state_e;

  function automatic logic [7:0] check_byte_update(input logic [7:0] crc_in,
                                                   input logic [7:0] data_in);
    logic [7:0] acc;
    acc = crc_in ^ data_in;
    for (int i = 0; i < 8; i++) begin
      if (acc[CRC_TOP]) begin
        acc = {acc[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        acc = {acc[6:0], 1'b0};
      end
    end
    return acc;
  endfunction

endpackage

// ==== hw/sd_if.sv ====
`timescale 1ns/100ps
interface sd_if;
  logic [15:0] word;
  logic        pos;
  logic        neg;

  modport src  (output word, input  pos, input  neg);
  modport sink (input  word, output pos, output neg);
endinterface

// ==== hw/sd_modulator.sv ====
`timescale 1ns/100ps
module sd_modulator
  import rc_readout_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  sd_if.sink        sd
);

  // ----------------------------------------------------------------
  // rate generator
  // ----------------------------------------------------------------
  logic [7:0]  phase_q;
  logic [8:0]  phase_sum;
  logic        step;
  logic [15:0] acc_q;
  logic [16:0] acc_sum;

  assign phase_sum = {1'b0, phase_q} + {1'b0, SD_RATE_STEP};
  assign step      = (phase_sum >= {1'b0, SD_RATE_WRAP});

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= 8'h00;
    end else if (step) begin
      phase_q <= 8'(phase_sum - {1'b0, SD_RATE_WRAP});
    end else begin
      phase_q <= phase_sum[7:0];
    end
  end

  // ----------------------------------------------------------------
  // first order modulator, carry is the bit
  // ----------------------------------------------------------------
  assign acc_sum = {1'b0, acc_q} + {1'b0, sd.word};

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q  <= 16'h0000;
      sd.pos <= 1'b0;
      sd.neg <= 1'b1;
    end else if (step) begin
      acc_q  <= acc_sum[15:0];
      sd.pos <= acc_sum[16];
      sd.neg <= ~acc_sum[16];
    end
  end

endmodule // sd_modulator

// ==== hw/rc_spi_readout.sv ====
// Behaviour
// - mode 1 link: clock idles low, master samples on falling edge.
// - slave only, transmit only; no command bytes are accepted.
// - five bytes msb first: wide word, narrow word, check byte.
// - check byte uses poly 0x07, register preset to 0xff.
// - per byte: xor in, eight shifts, xor 0x07 when bit 7 set.
// - check byte chosen so all five bytes reduce to 0x00.
// - normal operation within 100 ms of power-up or reset release.
// - fault signalling starts within 200 us of the condition.
// - fault pin toggles between 11 and 21 khz while a fault stands.
// - out-of-range flagged above 152-175 ma threshold; sampling continues.
// - any error replaces wide word with code, bits 15..6 ones.
// - error bit 3 marks self-check failure; bits 5..4 reserved.
// - error bit 2 is always zero.
// - error bit 1 set while out-of-range current is measured.
// - error bit 0 set on critical overload.
// - self-check failure held until power cycle, not cleared by reset.
// - wide word, error code included, feeds sigma-delta modulator.
// - sample words are offset binary, zero current is 32768.
// - 48 mhz bitstream on one pin, inverse on the other.
`timescale 1ns/100ps
module rc_spi_readout
  import rc_readout_pkg::*;
#(
  parameter int STARTUP_LEN = STARTUP_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        por_n_i,
  input  wire logic [15:0] wide_i,
  input  wire logic [15:0] narrow_i,
  input  wire logic        sample_valid_i,
  input  wire logic        overload_i,
  input  wire logic        self_check_fail_i,
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  output logic             fault_o,
  output logic             bitstream_pos_o,
  output logic             bitstream_neg_o,
  output logic             ready_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // start-up timer
  // ----------------------------------------------------------------
  logic [23:0] startup_q;
  logic        ready_q;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      startup_q <= 24'h000000;
      ready_q   <= 1'b0;
    end else if (!ready_q) begin
      if (startup_q == 24'(STARTUP_LEN - 1)) begin
        ready_q <= 1'b1;
      end
      startup_q <= startup_q + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // link input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cs_sync_q;
  logic [1:0] sclk_sync_q;
  logic       sclk_prev_q;
  logic       cs_n_s;
  logic       sclk_rise;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_q   <= 2'b11;
      sclk_sync_q <= 2'b00;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_sync_q   <= {cs_sync_q[0], cs_n_i};
      sclk_sync_q <= {sclk_sync_q[0], sclk_i};
      sclk_prev_q <= sclk_sync_q[1];
    end
  end

  assign cs_n_s    = cs_sync_q[1];
  assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;

  // ----------------------------------------------------------------
  // sample capture and range check
  // ----------------------------------------------------------------
  logic signed [16:0] wide_ext;
  logic        [16:0] wide_mag;
  logic               range_now;
  logic        [15:0] wide_enc_q;
  logic        [15:0] narrow_enc_q;
  logic               range_q;
  logic               overload_q;

  assign wide_ext  = {wide_i[15], wide_i};
  assign wide_mag  = wide_ext[16] ? 17'(-wide_ext) : 17'(wide_ext);
  assign range_now = (wide_mag > FAULT_CURRENT_THRESHOLD);

  // inputs are two's complement; flipping the sign bit adds 32768
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      wide_enc_q   <= ZERO_CODE;
      narrow_enc_q <= ZERO_CODE;
      range_q      <= 1'b0;
      overload_q   <= 1'b0;
    end else if (sample_valid_i && ready_q) begin
      wide_enc_q   <= {~wide_i[15], wide_i[14:0]};
      narrow_enc_q <= {~narrow_i[15], narrow_i[14:0]};
      range_q      <= range_now;
      overload_q   <= overload_i;
    end
  end

  // ----------------------------------------------------------------
  // self-check flag, cleared only by power-on
  // ----------------------------------------------------------------
  logic [1:0] por_sync_q;
  logic       por_n;
  logic       self_fail_q;

  // power-on clear asserts at once, but releases on the clock
  always_ff @(posedge clock_i or negedge por_n_i) begin
    if (!por_n_i) begin
      por_sync_q <= 2'b00;
    end else begin
      por_sync_q <= {por_sync_q[0], 1'b1};
    end
  end

  assign por_n = por_sync_q[1];

  always_ff @(posedge clock_i or negedge por_n) begin
    if (!por_n) begin
      self_fail_q <= 1'b0;
    end else if (self_check_fail_i) begin
      self_fail_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // wide word assembly
  // ----------------------------------------------------------------
  logic        any_err;
  logic [15:0] err_code;
  logic [15:0] word1_q;

  assign any_err  = self_fail_q | range_q | overload_q;
  assign err_code = {ERR_ONES,
                     RESERVED_LATER_USE,
                     self_fail_q,
                     ERR_ZERO_BIT,
                     range_q,
                     overload_q};

  // narrow word passes unchanged; the master discards it on error
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      word1_q <= ZERO_CODE;
    end else begin
      word1_q <= any_err ? err_code : wide_enc_q;
    end
  end

  // ----------------------------------------------------------------
  // check byte over the four data bytes
  // ----------------------------------------------------------------
  logic [7:0] crc_b1;
  logic [7:0] crc_b2;
  logic [7:0] crc_b3;
  logic [7:0] crc_b4;

  // feeding this value in as byte five leaves the register at zero
  assign crc_b1 = check_byte_update(CRC_PRESET, word1_q[15:8]);
  assign crc_b2 = check_byte_update(crc_b1, word1_q[7:0]);
  assign crc_b3 = check_byte_update(crc_b2, narrow_enc_q[15:8]);
  assign crc_b4 = check_byte_update(crc_b3, narrow_enc_q[7:0]);

  // ----------------------------------------------------------------
  // serial transmitter
  // ----------------------------------------------------------------
  link_state_e                  state_q;
  logic [FRAME_BITS-1:0]        shift_q;
  logic [5:0]                   bit_cnt_q;
  logic                         frame_done;
  logic                         miso_q;
  logic                         miso_oe_q;

  // snapshot taken at select, so the frame cannot tear mid-transfer
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= LINK_IDLE;
      shift_q   <= '0;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      unique case (state_q)
        LINK_IDLE: begin
          miso_oe_q <= 1'b0;
          if (!cs_n_s && ready_q) begin
            shift_q   <= {word1_q, narrow_enc_q, crc_b4};
            miso_q    <= 1'b0;
            miso_oe_q <= 1'b1;
            state_q   <= LINK_SHIFT;
          end
        end
        LINK_SHIFT: begin
          if (cs_n_s) begin
            miso_oe_q <= 1'b0;
            state_q   <= LINK_IDLE;
          end else if (sclk_rise) begin
            miso_q  <= frame_done ? 1'b0 : shift_q[FRAME_BITS-1];
            shift_q <= {shift_q[FRAME_BITS-2:0], 1'b0};
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bit counter, saturates once the frame is out
  // ----------------------------------------------------------------
  assign frame_done = (bit_cnt_q > FRAME_BITS_LAST);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 6'h00;
    end else if (state_q == LINK_IDLE) begin
      bit_cnt_q <= 6'h00;
    end else if (sclk_rise && !frame_done) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // the receive line is never sampled: transmit only

  // ----------------------------------------------------------------
  // fault pin oscillator
  // ----------------------------------------------------------------
  logic [11:0] fault_cnt_q;
  logic        fault_q;

  // first toggle comes the cycle after the flag, well inside the limit
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      fault_cnt_q <= 12'h000;
      fault_q     <= 1'b0;
    end else if (!any_err) begin
      fault_cnt_q <= 12'h000;
      fault_q     <= 1'b0;
    end else if (fault_cnt_q == 12'h000) begin
      fault_cnt_q <= FAULT_HALF_LAST;
      fault_q     <= ~fault_q;
    end else begin
      fault_cnt_q <= fault_cnt_q - 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // bitstream output
  // ----------------------------------------------------------------
  sd_if sd ();

  assign sd.word = word1_q;

  sd_modulator u_mod (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .sd      (sd)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign miso_o          = miso_q;
  assign miso_oe_o       = miso_oe_q;
  assign fault_o         = fault_q;
  assign bitstream_pos_o = sd.pos;
  assign bitstream_neg_o = sd.neg;
  assign ready_o         = ready_q;

endmodule // rc_spi_readout

// ==== bench/rc_spi_readout_assertions.sv ====
`timescale 1ns/100ps
module rc_spi_readout_assertions
  import rc_readout_pkg::*;
#(
  parameter int STARTUP_LEN = 16
) (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        por_n_i,
  input  wire logic [15:0] wide_i,
  input  wire logic [15:0] narrow_i,
  input  wire logic        sample_valid_i,
  input  wire logic        overload_i,
  input  wire logic        self_check_fail_i,
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        miso_o,
  input  wire logic        miso_oe_o,
  input  wire logic        fault_o,
  input  wire logic        bitstream_pos_o,
  input  wire logic        bitstream_neg_o,
  input  wire logic        ready_o
);
  logic [15:0] since_q;
  logic        seen_q;
  logic [3:0]  rise_age_q;
  logic        sclk_q;
  logic [31:0] run_q;

  // saturating, so a long idle never wraps back into the toggle window
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      since_q <= 16'hffff;
      seen_q  <= 1'b0;
    end else if ($changed(fault_o)) begin
      since_q <= 16'h0000;
      seen_q  <= 1'b1;
    end else if (since_q != 16'hffff) begin
      since_q <= since_q + 16'h0001;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_q     <= 1'b0;
      rise_age_q <= 4'hf;
    end else begin
      sclk_q     <= sclk_i;
      rise_age_q <= (sclk_i && !sclk_q) ? 4'h0 : ((rise_age_q == 4'hf) ? rise_age_q : rise_age_q + 4'h1);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_q <= 32'h0;
    end else begin
      run_q <= run_q + 32'h1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  property p_diff;        bitstream_neg_o == !bitstream_pos_o; endproperty
  property p_oe_idle;     cs_n_i [*8] |-> !miso_oe_o; endproperty
  property p_oe_on;       (!cs_n_i && ready_o) [*8] |-> miso_oe_o; endproperty
  property p_oe_ready;    !ready_o |-> !miso_oe_o; endproperty
  property p_ready_hold;  ready_o |=> ready_o; endproperty
  property p_ready_time;  $rose(ready_o) |-> (run_q >= STARTUP_LEN) && (run_q <= STARTUP_LEN + 4); endproperty
  property p_miso_edge;   $changed(miso_o) && miso_oe_o && $past(miso_oe_o) |-> rise_age_q <= 4'h7; endproperty
  property p_fault_rate;  $rose(fault_o) && seen_q |-> since_q >= 16'(FAULT_HALF_LAST); endproperty
  property p_fault_react;
    ready_o && sample_valid_i && overload_i && !fault_o && since_q > 16'hfa0 |-> ##[1:8] fault_o;
  endproperty

  a_diff:        assert property (p_diff) else $error("bitstream pair not inverse");
  a_oe_idle:     assert property (p_oe_idle) else $error("miso driven while deselected");
  a_oe_on:       assert property (p_oe_on) else $error("miso not driven while selected");
  a_oe_ready:    assert property (p_oe_ready) else $error("miso driven before ready");
  a_ready_hold:  assert property (p_ready_hold) else $error("ready dropped");
  a_ready_time:  assert property (p_ready_time) else $error("ready at wrong time");
  a_miso_edge:   assert property (p_miso_edge) else $error("miso changed away from rising sclk");
  a_fault_rate:  assert property (p_fault_rate) else $error("fault toggles too fast");
  a_fault_react: assert property (p_fault_react) else $error("fault pin slow to start");

  c_frame:  cover property (!cs_n_i && miso_oe_o);
  c_fault:  cover property ($rose(fault_o));
  c_ready:  cover property ($rose(ready_o));
endmodule // rc_spi_readout_assertions

bind rc_spi_readout rc_spi_readout_assertions #(.STARTUP_LEN(STARTUP_LEN)) i_rc_spi_readout_assertions (
  .clock_i(clock_i), .rstn_i(rstn_i), .por_n_i(por_n_i), .wide_i(wide_i), .narrow_i(narrow_i),
  .sample_valid_i(sample_valid_i), .overload_i(overload_i), .self_check_fail_i(self_check_fail_i),
  .cs_n_i(cs_n_i), .sclk_i(sclk_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .fault_o(fault_o),
  .bitstream_pos_o(bitstream_pos_o), .bitstream_neg_o(bitstream_neg_o), .ready_o(ready_o));

// ==== bench/spi_master_model.sv ====
`timescale 1ns/100ps
module spi_master_model (
  input  wire logic        clock_i,
  input  wire logic        start_i,
  input  wire logic        slow_i,
  input  wire logic        cut_i,
  input  wire logic        miso_i,
  output logic             cs_n_o,
  output logic             sclk_o,
  output logic             busy_o,
  output logic [39:0]      frame_o
);
  realtime half;

  // transmit-only slave, so no command line exists here
  initial begin
    cs_n_o  = 1'b1;
    sclk_o  = 1'b0;
    busy_o  = 1'b0;
    frame_o = '0;
    forever begin
      @(posedge clock_i iff start_i);
      #1;
      busy_o = 1'b1;
      half   = slow_i ? 200.0 : 128.0;
      cs_n_o = 1'b0;
      #(half);
      repeat (cut_i ? 12 : 40) begin
        sclk_o = 1'b1;
        #(half);
        sclk_o  = 1'b0;
        frame_o = {frame_o[38:0], miso_i};
        #(half);
      end
      cs_n_o = 1'b1;
      #260;
      busy_o = 1'b0;
    end
  end
endmodule // spi_master_model

// ==== bench/test_residual_current_spi_readout.sv ====
`timescale 1ns/100ps
module test_residual_current_spi_readout;
  import rc_readout_pkg::*;
  localparam int STARTUP = 16;
  logic        clock_i, rstn_i = 0, por_n_i = 0, sample_valid_i = 0, overload_i = 0, self_check_fail_i = 0;
  logic [15:0] wide_i = '0, narrow_i = '0;
  logic        cs_n_i, sclk_i, miso_o, miso_oe_o, fault_o, bitstream_pos_o, bitstream_neg_o, ready_o;
  logic        start = 0, slow = 0, cut = 0, busy, miso_last = 0, miso_line;
  logic [39:0] frame;
  int          mismatches = 0, num_checks = 0, cycles = 0, g;

  // ----------------------------------------------------------------
  // clock, line model, instances
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // released line floats, so show the inverse rather than a stale bit
  always @(posedge clock_i) if (miso_oe_o === 1'b1) miso_last <= miso_o;
  assign miso_line = (miso_oe_o === 1'b1) ? miso_o : ~miso_last;

  rc_spi_readout #(.STARTUP_LEN(STARTUP)) i_rc_spi_readout (
    .clock_i(clock_i), .rstn_i(rstn_i), .por_n_i(por_n_i), .wide_i(wide_i), .narrow_i(narrow_i),
    .sample_valid_i(sample_valid_i), .overload_i(overload_i), .self_check_fail_i(self_check_fail_i),
    .cs_n_i(cs_n_i), .sclk_i(sclk_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .fault_o(fault_o),
    .bitstream_pos_o(bitstream_pos_o), .bitstream_neg_o(bitstream_neg_o), .ready_o(ready_o));
  spi_master_model i_spi_master_model (
    .clock_i(clock_i), .start_i(start), .slow_i(slow), .cut_i(cut), .miso_i(miso_line),
    .cs_n_o(cs_n_i), .sclk_o(sclk_i), .busy_o(busy), .frame_o(frame));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] crc_of(input logic [39:0] f, input int n);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 0; i < n; i++) begin
      c = c ^ f[39-8*i -: 8];
      repeat (8) c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 200) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 200) mismatches++;
  endtask

  task automatic put(input logic [15:0] w, input logic [15:0] n, input logic ovl);
    @(posedge clock_i);
    wide_i         <= w;
    narrow_i       <= n;
    overload_i     <= ovl;
    sample_valid_i <= 1'b1;
    @(posedge clock_i);
    sample_valid_i <= 1'b0;
    wait_cycles(4);
  endtask

  task automatic read_frame();
    int n;
    n = 0;
    @(posedge clock_i);
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    wait_cycles(2);
    while (busy === 1'b1 && n < 4000) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 4000) mismatches++;
  endtask

  task automatic frame_case(input logic [15:0] w, input logic [15:0] n, input logic ovl, input logic [15:0] w1);
    logic [39:0] e;
    put(w, n, ovl);
    e       = {w1, n ^ ZERO_CODE, 8'h00};
    e[7:0]  = crc_of(e, 4);
    read_frame();
    chk(frame, e);
    chk(40'(crc_of(frame, 5)), 40'h0);
  endtask

  task automatic toggle_gap(output int gap);
    logic f0;
    gap = 0;
    f0  = fault_o;
    while (fault_o === f0 && gap < 9000) begin
      @(negedge clock_i);
      gap++;
    end
  endtask

  task automatic density(output int ones);
    ones = 0;
    repeat (1000) begin
      @(negedge clock_i);
      ones += int'(bitstream_pos_o === 1'b1);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    wait_cycles(8);
    rstn_i  <= 1'b1;
    por_n_i <= 1'b1;
    wait_ready();
    frame_case(16'h0320, 16'h6396, 1'b0, 16'h8320);
    slow <= 1'b1;
    read_frame();
    chk(frame, 40'h8320e3960e);
    slow <= 1'b0;
    cut  <= 1'b1;
    read_frame();
    cut  <= 1'b0;
    read_frame();
    chk(frame, 40'h8320e3960e);
    frame_case(16'h343e, 16'h0010, 1'b0, 16'hb43e);
    frame_case(16'hcbc1, 16'h0010, 1'b0, 16'hffc2);
    frame_case(16'h343f, 16'h0020, 1'b0, 16'hffc2);
    toggle_gap(g);
    toggle_gap(g);
    chk(40'(g), 40'(FAULT_HALF_CYCLES));
    frame_case(16'h0000, 16'h0000, 1'b0, 16'h8000);
    wait_cycles(10);
    chk(40'(fault_o), 40'h0);
    wait_cycles(3000);
    density(g);
    chk(40'(g >= 480 && g <= 520), 40'h1);
    frame_case(16'h0100, 16'h0000, 1'b1, 16'hffc1);
    density(g);
    chk(40'(g >= 900), 40'h1);
    @(posedge clock_i);
    self_check_fail_i <= 1'b1;
    @(posedge clock_i);
    self_check_fail_i <= 1'b0;
    frame_case(16'h0100, 16'h0000, 1'b0, 16'hffc8);
    rstn_i <= 1'b0;
    wait_cycles(8);
    chk(40'(ready_o), 40'h0);
    rstn_i <= 1'b1;
    wait_ready();
    frame_case(16'h0100, 16'h0000, 1'b0, 16'hffc8);
    por_n_i <= 1'b0;
    wait_cycles(4);
    por_n_i <= 1'b1;
    frame_case(16'h0000, 16'h1234, 1'b0, 16'h8000);
    final_report();
  end
endmodule // test_residual_current_spi_readout
